// ---- hdl/fgt_pkg.sv ----
// Behaviour
// - core 2 input A uses its trim
// - core 2 input B uses separate trim
// - core 3 input C uses its trim
// - core 3 input D uses separate trim
// - core 4 has one independent trim
// - core 5 has one own trim
// - trims default from fuse, writes override
package fgt_pkg;

  localparam int unsigned FGT_NUM_TRIM = 6;
  localparam int unsigned FGT_ADDR_W = 12;
  localparam int unsigned FGT_DATA_W = 32;
  localparam int unsigned FGT_STRB_W = 4;
  localparam int unsigned FGT_SYNC_W = 2;

  // Printed offsets are register indices; byte address is four times the index
  localparam logic [FGT_ADDR_W-1:0] FGT_IDX_C2A = 12'h362;
  localparam logic [FGT_ADDR_W-1:0] FGT_IDX_C2B = 12'h363;
  localparam logic [FGT_ADDR_W-1:0] FGT_IDX_C3C = 12'h364;
  localparam logic [FGT_ADDR_W-1:0] FGT_IDX_C3D = 12'h365;
  localparam logic [FGT_ADDR_W-1:0] FGT_IDX_C4 = 12'h366;
  localparam logic [FGT_ADDR_W-1:0] FGT_IDX_C5 = 12'h367;
  localparam logic [FGT_ADDR_W-1:0] FGT_IDX_CTRL = 12'h368;
  localparam logic [FGT_ADDR_W-1:0] FGT_IDX_STAT = 12'h369;
  localparam int unsigned FGT_IDX_SHIFT = 2;

  localparam int unsigned FGT_GAIN_LSB = 0;
  localparam int unsigned FGT_GAIN_W = 5;
  localparam int unsigned FGT_REG_W = 8;
  localparam logic [FGT_REG_W-1:0] FGT_TRIM_RST = 8'h00;

  localparam int unsigned FGT_CTRL_EN_BIT = 0;
  localparam int unsigned FGT_CTRL_RELOAD_BIT = 1;
  localparam logic [FGT_REG_W-1:0] FGT_CTRL_RST = 8'h01;

  localparam int unsigned FGT_STAT_LOADED_BIT = 0;
  localparam int unsigned FGT_STAT_PEND_BIT = 1;
  localparam int unsigned FGT_STAT_C2SEL_BIT = 2;
  localparam int unsigned FGT_STAT_C3SEL_BIT = 3;

  typedef enum logic [2:0] {
    FGT_SLOT_C2A = 3'b000,
    FGT_SLOT_C2B = 3'b001,
    FGT_SLOT_C3C = 3'b010,
    FGT_SLOT_C3D = 3'b011,
    FGT_SLOT_C4 = 3'b100,
    FGT_SLOT_C5 = 3'b101
  } fgt_slot_t;

  typedef enum logic {
    FGT_FUSE_IDLE = 1'b0,
    FGT_FUSE_WAIT = 1'b1
  } fgt_fuse_state_t;

  typedef logic [FGT_REG_W-1:0] fgt_byte_t;
  typedef fgt_byte_t [FGT_NUM_TRIM-1:0] fgt_bank_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [FGT_ADDR_W-1:0] paddr;
    logic [FGT_DATA_W-1:0] pwdata;
    logic [FGT_STRB_W-1:0] pstrb;
  } fgt_apb_req_t;

  typedef struct packed {
    logic [FGT_GAIN_W-1:0] core2;
    logic [FGT_GAIN_W-1:0] core3;
    logic [FGT_GAIN_W-1:0] core4;
    logic [FGT_GAIN_W-1:0] core5;
  } fgt_gains_t;

endpackage

// ---- hdl/fgt_sync2.sv ----
module fgt_sync2 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic async_in,
  output logic sync_out
);
  import fgt_pkg::*;

  logic meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_out <= 1'b0;
    end else if (pce) begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ---- hdl/fgt_top.sv ----
module fgt_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire fgt_pkg::fgt_apb_req_t apb_req,
  output logic pready,
  output logic [fgt_pkg::FGT_DATA_W-1:0] prdata,
  output logic pslverr,
  input wire logic fuse_valid,
  input wire fgt_pkg::fgt_bank_t fuse_bank,
  output logic fuse_req,
  input wire logic core2_sel_input_b,
  input wire logic core3_sel_input_d,
  output fgt_pkg::fgt_gains_t gains
);
  import fgt_pkg::*;

  localparam int unsigned IDXW = FGT_ADDR_W - FGT_IDX_SHIFT;

  // Bus decode
  logic setup;
  logic access_done;
  logic wr_done;
  logic [IDXW-1:0] req_idx;
  logic addr_aligned;
  logic idx_is_trim;
  logic idx_is_ctrl;
  logic idx_is_stat;
  logic mapped;
  logic [2:0] trim_slot;
  logic byte0_wr;

  // Register state
  fgt_bank_t bank;
  logic [FGT_NUM_TRIM-1:0] trim_wr;
  logic trim_en_q;
  logic fuse_loaded_q;
  logic reload_wr;
  fgt_fuse_state_t fuse_state_q;
  fgt_fuse_state_t fuse_state_d;
  logic fuse_take;

  // Synchronised input selects
  logic [1:0] sel_raw;
  logic [1:0] sel_sync;

  // Read path
  logic [FGT_DATA_W-1:0] rdata_d;
  fgt_byte_t stat_byte;
  fgt_byte_t ctrl_byte;

  // Gain selection
  fgt_byte_t core2_pick;
  fgt_byte_t core3_pick;

  // Applied gains, one register per core
  logic [FGT_GAIN_W-1:0] core2_gain_q;
  logic [FGT_GAIN_W-1:0] core3_gain_q;
  logic [FGT_GAIN_W-1:0] core4_gain_q;
  logic [FGT_GAIN_W-1:0] core5_gain_q;

  assign setup = apb_req.psel & ~apb_req.penable;
  assign access_done = apb_req.psel & apb_req.penable & pready;
  assign wr_done = access_done & apb_req.pwrite & ~pslverr;
  assign byte0_wr = wr_done & apb_req.pstrb[0];

  assign req_idx = apb_req.paddr[FGT_ADDR_W-1:FGT_IDX_SHIFT];
  assign addr_aligned = (apb_req.paddr[FGT_IDX_SHIFT-1:0] == 2'h0);

  assign idx_is_trim = (req_idx >= IDXW'(FGT_IDX_C2A)) &&
                       (req_idx <= IDXW'(FGT_IDX_C5));
  assign idx_is_ctrl = (req_idx == IDXW'(FGT_IDX_CTRL));
  assign idx_is_stat = (req_idx == IDXW'(FGT_IDX_STAT));
  assign mapped = addr_aligned & (idx_is_trim | idx_is_ctrl | idx_is_stat);

  assign trim_slot = 3'(req_idx - IDXW'(FGT_IDX_C2A));

  // One write strobe per trim slot
  genvar gi;
  generate
    for (gi = 0; gi < FGT_NUM_TRIM; gi++) begin : g_trim
      assign trim_wr[gi] = byte0_wr & addr_aligned & idx_is_trim &
                           (trim_slot == 3'(gi));

      // Reserved bits 7:5 are stored as written; software keeps them zero
      fgt_trim_reg #(
        .WIDTH(FGT_REG_W)
      ) u_trim (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .fuse_load(fuse_take),
        .fuse_value(fuse_bank[gi]),
        .wr_en(trim_wr[gi]),
        .wr_value(apb_req.pwdata[FGT_REG_W-1:0]),
        .value_q(bank[gi])
      );
    end
  endgenerate

  assign reload_wr = byte0_wr & addr_aligned & idx_is_ctrl &
                     apb_req.pwdata[FGT_CTRL_RELOAD_BIT];

  // APB answer: read data and error are prepared in the setup cycle,
  // so every transfer completes with no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (pce) begin
      pready <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (pce) begin
      pslverr <= setup & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (pce) begin
      if (setup & ~apb_req.pwrite) begin
        prdata <= rdata_d;
      end else if (access_done) begin
        prdata <= '0;
      end
    end
  end

  always_comb begin
    stat_byte = '0;
    stat_byte[FGT_STAT_LOADED_BIT] = fuse_loaded_q;
    stat_byte[FGT_STAT_PEND_BIT] = (fuse_state_q == FGT_FUSE_WAIT);
    stat_byte[FGT_STAT_C2SEL_BIT] = sel_sync[0];
    stat_byte[FGT_STAT_C3SEL_BIT] = sel_sync[1];
  end

  always_comb begin
    ctrl_byte = '0;
    ctrl_byte[FGT_CTRL_EN_BIT] = trim_en_q;
  end

  // Narrow registers sit in the low byte; upper bits read zero
  always_comb begin
    rdata_d = '0;
    if (addr_aligned) begin
      if (idx_is_trim) begin
        unique case (fgt_slot_t'(trim_slot))
          FGT_SLOT_C2A: rdata_d[FGT_REG_W-1:0] = bank[FGT_SLOT_C2A];
          FGT_SLOT_C2B: rdata_d[FGT_REG_W-1:0] = bank[FGT_SLOT_C2B];
          FGT_SLOT_C3C: rdata_d[FGT_REG_W-1:0] = bank[FGT_SLOT_C3C];
          FGT_SLOT_C3D: rdata_d[FGT_REG_W-1:0] = bank[FGT_SLOT_C3D];
          FGT_SLOT_C4: rdata_d[FGT_REG_W-1:0] = bank[FGT_SLOT_C4];
          FGT_SLOT_C5: rdata_d[FGT_REG_W-1:0] = bank[FGT_SLOT_C5];
          default: rdata_d = '0;
        endcase
      end else if (idx_is_ctrl) begin
        rdata_d[FGT_REG_W-1:0] = ctrl_byte;
      end else if (idx_is_stat) begin
        rdata_d[FGT_REG_W-1:0] = stat_byte;
      end
    end
  end

  // Control: global trim enable; reload bit is a self-clearing request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_en_q <= FGT_CTRL_RST[FGT_CTRL_EN_BIT];
    end else if (pce) begin
      if (byte0_wr & addr_aligned & idx_is_ctrl) begin
        trim_en_q <= apb_req.pwdata[FGT_CTRL_EN_BIT];
      end
    end
  end

  // Fuse fetch: starts by itself after reset so defaults come from fuses
  always_comb begin
    fuse_state_d = fuse_state_q;
    unique case (fuse_state_q)
      FGT_FUSE_IDLE: begin
        if (reload_wr) begin
          fuse_state_d = FGT_FUSE_WAIT;
        end
      end
      FGT_FUSE_WAIT: begin
        if (fuse_valid) begin
          fuse_state_d = FGT_FUSE_IDLE;
        end
      end
    endcase
  end

  // Fuse data are taken only while a fetch is pending
  assign fuse_take = (fuse_state_q == FGT_FUSE_WAIT) & fuse_valid;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_state_q <= FGT_FUSE_WAIT;
    end else if (pce) begin
      fuse_state_q <= fuse_state_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_req <= 1'b1;
    end else if (pce) begin
      fuse_req <= (fuse_state_d == FGT_FUSE_WAIT);
    end
  end

  // Set by a completed fetch wins over the clear from a new reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_loaded_q <= 1'b0;
    end else if (pce) begin
      if (fuse_take) begin
        fuse_loaded_q <= 1'b1;
      end else if (reload_wr) begin
        fuse_loaded_q <= 1'b0;
      end
    end
  end

  // Mux selects arrive from pins, so they are resynchronised first
  assign sel_raw = {core3_sel_input_d, core2_sel_input_b};

  generate
    for (gi = 0; gi < FGT_SYNC_W; gi++) begin : g_sync
      fgt_sync2 u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .async_in(sel_raw[gi]),
        .sync_out(sel_sync[gi])
      );
    end
  endgenerate

  // Dual-input cores pick the trim that matches the sampled input
  always_comb begin
    if (sel_sync[0]) begin
      core2_pick = bank[FGT_SLOT_C2B];
    end else begin
      core2_pick = bank[FGT_SLOT_C2A];
    end
  end

  always_comb begin
    if (sel_sync[1]) begin
      core3_pick = bank[FGT_SLOT_C3D];
    end else begin
      core3_pick = bank[FGT_SLOT_C3C];
    end
  end

  // Only the 5-bit gain field drives the cores; disabled trim applies zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core2_gain_q <= '0;
    end else if (pce) begin
      if (trim_en_q) begin
        core2_gain_q <= core2_pick[FGT_GAIN_LSB +: FGT_GAIN_W];
      end else begin
        core2_gain_q <= '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core3_gain_q <= '0;
    end else if (pce) begin
      if (trim_en_q) begin
        core3_gain_q <= core3_pick[FGT_GAIN_LSB +: FGT_GAIN_W];
      end else begin
        core3_gain_q <= '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core4_gain_q <= '0;
    end else if (pce) begin
      if (trim_en_q) begin
        core4_gain_q <= bank[FGT_SLOT_C4][FGT_GAIN_LSB +: FGT_GAIN_W];
      end else begin
        core4_gain_q <= '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core5_gain_q <= '0;
    end else if (pce) begin
      if (trim_en_q) begin
        core5_gain_q <= bank[FGT_SLOT_C5][FGT_GAIN_LSB +: FGT_GAIN_W];
      end else begin
        core5_gain_q <= '0;
      end
    end
  end

  // Pure wiring, so each gain still leaves straight from its flip-flop
  assign gains = '{
    core2: core2_gain_q,
    core3: core3_gain_q,
    core4: core4_gain_q,
    core5: core5_gain_q
  };

endmodule

// ---- hdl/fgt_trim_reg.sv ----
module fgt_trim_reg #(
  parameter int unsigned WIDTH = fgt_pkg::FGT_REG_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire logic fuse_load,
  input wire logic [WIDTH-1:0] fuse_value,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_value,
  output logic [WIDTH-1:0] value_q
);
  import fgt_pkg::*;

  // A write in the same cycle as a fuse load wins: software has the last word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_q <= WIDTH'(FGT_TRIM_RST);
    end else if (pce) begin
      if (wr_en) begin
        value_q <= wr_value;
      end else if (fuse_load) begin
        value_q <= fuse_value;
      end
    end
  end

endmodule

// ---- tb/fgt_top_properties.sv ----
module fgt_top_properties import fgt_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pce,
  input wire fgt_pkg::fgt_apb_req_t apb_req,
  input wire logic pready,
  input wire logic [fgt_pkg::FGT_DATA_W-1:0] prdata,
  input wire logic pslverr,
  input wire logic fuse_valid,
  input wire fgt_pkg::fgt_bank_t fuse_bank,
  input wire logic fuse_req,
  input wire logic core2_sel_input_b,
  input wire logic core3_sel_input_d,
  input wire fgt_pkg::fgt_gains_t gains
);
  localparam logic [11:0] A_C4 = FGT_IDX_C4 << FGT_IDX_SHIFT;
  localparam logic [11:0] A_C5 = FGT_IDX_C5 << FGT_IDX_SHIFT;
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_write(logic [11:0] a);
    apb_req.psel && apb_req.penable && apb_req.pwrite && pready && !pslverr && apb_req.pstrb[0] && apb_req.paddr == a;
  endsequence
  // A write in flight could win the slot, so only quiet loads are judged
  sequence s_fuse_take;
    fuse_req && fuse_valid && pce && !(apb_req.psel && apb_req.penable && apb_req.pwrite);
  endsequence
  a_setup_gets_ready: assert property (apb_req.psel && !apb_req.penable && pce |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready && pce |=> !pready)
    else $error("ready held too long");
  a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_fuse_req_held: assert property (fuse_req && !fuse_valid |=> fuse_req)
    else $error("fuse request dropped early");
  a_fuse_req_drops: assert property (s_fuse_take |=> !fuse_req)
    else $error("fuse request not cleared");
  a_fuse_gain_applied: assert property (s_fuse_take |-> ##2
    gains.core4 == $past(fuse_bank[4][4:0], 2) && gains.core5 == $past(fuse_bank[5][4:0], 2))
    else $error("fuse defaults not applied");
  a_core4_write_applied: assert property (s_write(A_C4) |-> ##2 gains.core4 == $past(apb_req.pwdata[4:0], 2))
    else $error("core 4 gain not applied");
  a_core5_write_applied: assert property (s_write(A_C5) |-> ##2 gains.core5 == $past(apb_req.pwdata[4:0], 2))
    else $error("core 5 gain not applied");
endmodule

bind fgt_top fgt_top_properties u_fgt_top_properties (.pclk, .presetn, .pce, .apb_req, .pready, .prdata, .pslverr,
  .fuse_valid, .fuse_bank, .fuse_req, .core2_sel_input_b, .core3_sel_input_d, .gains);

// ---- tb/tb_top.sv ----
module tb_top import fgt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic pce = 1'b1;
  fgt_apb_req_t req = '0;
  logic fuse_valid = 1'b0;
  fgt_bank_t fuse_bank = '0;
  logic sel_b = 1'b0;
  logic sel_d = 1'b0;
  logic pready;
  logic pslverr;
  logic fuse_req;
  logic [31:0] prdata;
  fgt_gains_t gains;
  logic [7:0] expv [6];
  int errors = 0;
  int tests_run = 0;
  logic [3:0] strb = 4'hF;
  localparam logic [11:0] A_CTRL = 12'(FGT_IDX_CTRL << FGT_IDX_SHIFT);
  localparam logic [11:0] A_STAT = 12'(FGT_IDX_STAT << FGT_IDX_SHIFT);
  localparam logic [31:0] ST_LOADED = 32'h1 << FGT_STAT_LOADED_BIT;
  localparam logic [31:0] ST_PEND = 32'h1 << FGT_STAT_PEND_BIT;
  localparam logic [31:0] ST_SELS = (32'h1 << FGT_STAT_C2SEL_BIT) | (32'h1 << FGT_STAT_C3SEL_BIT);
  localparam logic [31:0] CT_EN = 32'h1 << FGT_CTRL_EN_BIT;
  localparam logic [31:0] CT_RELOAD = 32'h1 << FGT_CTRL_RELOAD_BIT;
  always #4 pclk = ~pclk;
  fgt_top u_fgt_top (.pclk(pclk), .presetn(presetn), .pce(pce), .apb_req(req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .fuse_valid(fuse_valid), .fuse_bank(fuse_bank), .fuse_req(fuse_req),
    .core2_sel_input_b(sel_b), .core3_sel_input_d(sel_d), .gains(gains));
  function automatic logic [11:0] addr_of(input int i);
    return 12'((FGT_IDX_C2A + 12'(i)) << FGT_IDX_SHIFT);
  endfunction
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Idle cycle first, so a release and the next setup never land in one step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
    output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd, pstrb: strb};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge pclk);
    end
    if (n == 16) errors++;
    rd = prdata;
    er = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    check(rd, exp);
    check({31'h0, er}, {31'h0, eexp});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic eexp);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
    check({31'h0, er}, {31'h0, eexp});
  endtask
  task automatic chk_gains;
    check({12'h0, gains}, {12'h0, expv[sel_b ? 1 : 0][4:0], expv[sel_d ? 3 : 2][4:0], expv[4][4:0], expv[5][4:0]});
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    check({31'h0, fuse_req}, 32'h1);
    for (int i = 0; i < 6; i++) rd_chk(addr_of(i), 32'h0, 1'b0);
    @(posedge pclk);
    for (int i = 0; i < 6; i++) begin
      expv[i] = 8'(i * 5 + 3);
      fuse_bank[i] <= 8'(i * 5 + 3);
    end
    fuse_valid <= 1'b1;
    @(posedge pclk);
    fuse_valid <= 1'b0;
    @(posedge pclk);
    check({31'h0, fuse_req}, 32'h0);
    for (int i = 0; i < 6; i++) rd_chk(addr_of(i), {24'h0, expv[i]}, 1'b0);
    chk_gains();
    sel_b <= 1'b1;
    sel_d <= 1'b1;
    repeat (4) @(posedge pclk);
    chk_gains();
    rd_chk(A_STAT, ST_LOADED | ST_SELS, 1'b0);
    expv[4] = 8'h1F;
    wr(addr_of(4), 32'h1F, 1'b0);
    repeat (3) @(posedge pclk);
    chk_gains();
    for (int i = 0; i < 6; i++) begin
      expv[i] = 8'(31 - i * 3);
      wr(addr_of(i), {24'h0, expv[i]}, 1'b0);
    end
    for (int i = 0; i < 6; i++) rd_chk(addr_of(i), {24'h0, expv[i]}, 1'b0);
    repeat (3) @(posedge pclk);
    chk_gains();
    sel_b <= 1'b0;
    sel_d <= 1'b0;
    repeat (4) @(posedge pclk);
    chk_gains();
    wr(12'hDA8, 32'h1F, 1'b1);
    rd_chk(12'hDA8, 32'h0, 1'b1);
    wr(addr_of(4) + 12'h1, 32'h05, 1'b1);
    rd_chk(addr_of(4), {24'h0, expv[4]}, 1'b0);
    // Without byte lane 0 the write is dropped; the read below proves it
    strb = 4'h0;
    wr(addr_of(5), 32'h01, 1'b0);
    strb = 4'hF;
    // A late fuse strobe must not undo software writes
    @(posedge pclk);
    fuse_bank <= {6{8'h0A}};
    fuse_valid <= 1'b1;
    @(posedge pclk);
    fuse_valid <= 1'b0;
    rd_chk(addr_of(5), {24'h0, expv[5]}, 1'b0);
    // Trim disable forces zero gains; enabling again restores them
    wr(A_CTRL, 32'h0, 1'b0);
    rd_chk(A_CTRL, 32'h0, 1'b0);
    check({12'h0, gains}, 32'h0);
    wr(A_CTRL, CT_EN, 1'b0);
    repeat (2) @(posedge pclk);
    chk_gains();
    // Clock enable low freezes the select pipeline and the gains
    pce <= 1'b0;
    sel_b <= 1'b1;
    repeat (5) @(posedge pclk);
    check({27'h0, gains.core2}, {27'h0, expv[0][4:0]});
    pce <= 1'b1;
    sel_b <= 1'b0;
    // A reload fetches the fuse defaults again over written values
    wr(A_CTRL, CT_EN | CT_RELOAD, 1'b0);
    rd_chk(A_STAT, ST_PEND, 1'b0);
    check({31'h0, fuse_req}, 32'h1);
    rd_chk(A_CTRL, CT_EN, 1'b0);
    @(posedge pclk);
    fuse_valid <= 1'b1;
    @(posedge pclk);
    fuse_valid <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      expv[i] = 8'h0A;
      rd_chk(addr_of(i), {24'h0, expv[i]}, 1'b0);
    end
    rd_chk(A_STAT, ST_LOADED, 1'b0);
    chk_gains();
    give_verdict();
  end
  initial begin
    repeat (3000) @(posedge pclk);
    errors++;
    give_verdict();
  end
endmodule
